// ---- inc/dpdc_pkg.sv ----
package dpdc_pkg;
   // register indices; byte address on the bus is four times the index
   localparam logic [7:0] IDX_TMR = 8'hF1;
   localparam logic [7:0] IDX_CNT1 = 8'hF2;
   localparam logic [7:0] IDX_SECOND_PRESCALER_SETUP = 8'hF3;
   localparam logic [7:0] IDX_CNT0 = 8'hF4;
   localparam logic [7:0] IDX_FIRST_PRESCALER_SETUP = 8'hF5;
   localparam logic [7:0] IDX_STAT = 8'hE0;
   localparam logic [7:0] IDX_MASK = 8'hE1;
   localparam logic [7:0] IDX_OPT = 8'hE2;
   localparam int ADDR_W = 12;

   // timer mode control fields
   localparam int TMR_LD0 = 0;
   localparam int TMR_EN0 = 1;
   localparam int TMR_LD1 = 2;
   localparam int TMR_EN1 = 3;
   localparam int TMR_TIN_LO = 6;
   localparam logic [7:0] TMR_LD_MASK = 8'h05;
   localparam logic [7:0] TMR_RST = 8'h00;
   localparam logic [1:0] TIN_EXTCLK = 2'h0;
   localparam logic [1:0] TIN_GATE = 2'h1;
   localparam logic [1:0] TIN_TRIG_NR = 2'h2;
   localparam logic [1:0] TIN_TRIG_RT = 2'h3;

   // prescaler setup fields, plus prescaler and counter end and reset values
   localparam int PRE_MODE = 0;
   localparam int PRE_SRC = 1;
   localparam int PRE_RATIO_LO = 2;
   localparam logic [7:0] PRE_RST = 8'h00;
   localparam logic [5:0] PRE_END = 6'h01;
   localparam logic [7:0] CNT_END = 8'h01;
   localparam logic [7:0] CNT_RST = 8'h00;

   // clocking
   localparam int MCLK_NS = 40;
   localparam int EMI_CYCLE_NS = 250;
   localparam int EMI_MAX_MHZ = 4;
   localparam logic [2:0] LOWEMI_CYC = 3'((EMI_CYCLE_NS + MCLK_NS - 1) / MCLK_NS);
   localparam logic [2:0] STD_CYC = 3'h2;
   localparam logic [1:0] INT_DIV_LAST = 2'h3;
endpackage : dpdc_pkg

// ---- rtl/dpdc_chan.sv ----
`timescale 1ns/1ps
module dpdc_chan
   import dpdc_pkg::*;
(
   input wire logic mclk,
   input wire logic nrst,
   input wire logic tick,
   input wire logic run,
   input wire logic load,
   input wire logic [7:0] initVal,
   input wire logic [5:0] ratio,
   input wire logic modulo,
   output logic [7:0] count,
   output logic eoc,
   output logic halted
);
   logic [5:0] pre_q;
   logic [7:0] cnt_q;
   logic halt_q;
   logic eoc_q;
   wire logic active = tick & run & ~halt_q;
   wire logic preEnd = (pre_q == PRE_END);
   wire logic cntEnd = (cnt_q == CNT_END);

   // ratio 0 runs 64 ticks and count 0 runs 256, both by wrapping through zero
   always_ff @(posedge mclk) begin
      if (!nrst) begin
         pre_q <= 6'h00;
         cnt_q <= CNT_RST;
         halt_q <= 1'b1;
         eoc_q <= 1'b0;
      end else begin
         eoc_q <= 1'b0;
         if (load) begin
            pre_q <= ratio;
            cnt_q <= initVal;
            halt_q <= 1'b0;
         end else if (active) begin
            if (preEnd) begin
               pre_q <= ratio;
               if (cntEnd) begin
                  eoc_q <= 1'b1;
                  if (modulo) begin
                     cnt_q <= initVal;
                  end else begin
                     cnt_q <= CNT_RST;
                     halt_q <= 1'b1;
                  end
               end else begin
                  cnt_q <= cnt_q - 8'h01;
               end
            end else begin
               pre_q <= pre_q - 6'h01;
            end
         end
      end
   end

   assign count = cnt_q;
   assign eoc = eoc_q;
   assign halted = halt_q;
endmodule : dpdc_chan

// ---- rtl/dpdc_timer_top.sv ----
// Design decision made here: register access over APB.
`timescale 1ns/1ps
module dpdc_timer_top
   import dpdc_pkg::*;
(
   input wire logic mclk,
   input wire logic nrst,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [ADDR_W-1:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic [2:0] fixedInputLines,
   output logic [2:0] fixedInSync,
   output logic firstCounterIrq,
   output logic secondCounterIrq,
   output logic irq
);
   // ---------------- input synchronisers ----------------
   logic [2:0] s1_q;
   logic [2:0] s2_q;
   logic [2:0] s3_q;
   logic [2:0] lvl_q;

   // a change counts only when the last two stages agree
   for (genvar i = 0; i < 3; i++) begin : g_sync
      always_ff @(posedge mclk) begin
         if (!nrst) begin
            s1_q[i] <= 1'b0;
            s2_q[i] <= 1'b0;
            s3_q[i] <= 1'b0;
            lvl_q[i] <= 1'b0;
         end else begin
            s1_q[i] <= fixedInputLines[i];
            s2_q[i] <= s1_q[i];
            s3_q[i] <= s2_q[i];
            if (s2_q[i] == s3_q[i]) begin
               lvl_q[i] <= s3_q[i];
            end
         end
      end
   end

   assign fixedInSync = lvl_q;
   wire logic timerInputPin = lvl_q[0];
   wire logic pinFall = lvl_q[0] & (s2_q[0] == s3_q[0]) & ~s3_q[0];

   // ---------------- register decode ----------------
   logic [7:0] tmr_q;
   logic [7:0] init0_q;
   logic [7:0] init1_q;
   logic [7:0] first_prescaler_setup_q;
   logic [7:0] second_prescaler_setup_q;
   logic [1:0] stat_q;
   logic [1:0] mask_q;
   logic emi_q;
   logic emiLock_q;
   logic [31:0] prdata_q;
   logic pslverr_q;
   logic trigRun_q;
   logic irq0_q;
   logic irq1_q;

   wire logic [ADDR_W-1:0] addrTmr = {2'b00, IDX_TMR, 2'b00};
   wire logic [ADDR_W-1:0] addrCnt1 = {2'b00, IDX_CNT1, 2'b00};
   wire logic [ADDR_W-1:0] addrPre1 = {2'b00, IDX_SECOND_PRESCALER_SETUP, 2'b00};
   wire logic [ADDR_W-1:0] addrCnt0 = {2'b00, IDX_CNT0, 2'b00};
   wire logic [ADDR_W-1:0] addrPre0 = {2'b00, IDX_FIRST_PRESCALER_SETUP, 2'b00};
   wire logic [ADDR_W-1:0] addrStat = {2'b00, IDX_STAT, 2'b00};
   wire logic [ADDR_W-1:0] addrMask = {2'b00, IDX_MASK, 2'b00};
   wire logic [ADDR_W-1:0] addrOpt = {2'b00, IDX_OPT, 2'b00};

   wire logic selTmr = (paddr == addrTmr);
   wire logic selCnt1 = (paddr == addrCnt1);
   wire logic selPre1 = (paddr == addrPre1);
   wire logic selCnt0 = (paddr == addrCnt0);
   wire logic selPre0 = (paddr == addrPre0);
   wire logic selStat = (paddr == addrStat);
   wire logic selMask = (paddr == addrMask);
   wire logic selOpt = (paddr == addrOpt);
   wire logic hit = selTmr | selCnt1 | selPre1 | selCnt0 | selPre0 | selStat | selMask | selOpt;

   wire logic setup = psel & ~penable;
   wire logic wrEn = psel & penable & pwrite;
   wire logic wrTmr = wrEn & selTmr;
   wire logic wrStat = wrEn & selStat;
   wire logic wrMask = wrEn & selMask;
   wire logic ldBit0 = wrTmr & pwdata[TMR_LD0];
   wire logic ldBit1 = wrTmr & pwdata[TMR_LD1];

   // ---------------- timer clock enables ----------------
   // the low-EMI path cannot run the timer clock at the crystal rate here, so it
   // is paced to the fastest rate that still respects the 250 ns floor
   logic [2:0] tdiv_q;
   logic [1:0] idiv_q;
   wire logic [2:0] tdivLast = emi_q ? (LOWEMI_CYC - 3'h1) : (STD_CYC - 3'h1);
   wire logic tclkEn = (tdiv_q >= tdivLast);
   wire logic intTick = tclkEn & (idiv_q == INT_DIV_LAST);

   always_ff @(posedge mclk) begin
      if (!nrst) begin
         tdiv_q <= 3'h0;
         idiv_q <= 2'h0;
      end else begin
         tdiv_q <= tclkEn ? 3'h0 : tdiv_q + 3'h1;
         if (tclkEn) begin
            idiv_q <= idiv_q + 2'h1;
         end
      end
   end

   // ---------------- counter steering ----------------
   wire logic [1:0] tinMode = tmr_q[TMR_TIN_LO +: 2];
   wire logic src1Int = second_prescaler_setup_q[PRE_SRC];
   wire logic run0 = tmr_q[TMR_EN0];
   wire logic run1 = tmr_q[TMR_EN1];
   wire logic isTrig = (tinMode == TIN_TRIG_NR) | (tinMode == TIN_TRIG_RT);
   wire logic isGate = (tinMode == TIN_GATE);
   wire logic trigEdge = pinFall & isTrig & src1Int & run1;
   wire logic trigLoad = trigEdge & ((tinMode == TIN_TRIG_RT) | ~trigRun_q);
   wire logic intPass = intTick & (~isGate | timerInputPin) & (~isTrig | trigRun_q);
   wire logic extPass = pinFall & (tinMode == TIN_EXTCLK);
   wire logic tick0 = intTick;
   wire logic tick1 = src1Int ? intPass : extPass;
   wire logic ld0 = ldBit0;
   wire logic ld1 = ldBit1 | trigLoad;

   logic [7:0] cnt0;
   logic [7:0] cnt1;
   logic eoc0;
   logic eoc1;
   logic halted0;
   logic halted1;

   // two identical channels, each with its own prescaler
   dpdc_chan u_chan0 (
      .mclk(mclk),
      .nrst(nrst),
      .tick(tick0),
      .run(run0),
      .load(ld0),
      .initVal(init0_q),
      .ratio(first_prescaler_setup_q[PRE_RATIO_LO +: 6]),
      .modulo(first_prescaler_setup_q[PRE_MODE]),
      .count(cnt0),
      .eoc(eoc0),
      .halted(halted0)
   );

   dpdc_chan u_chan1 (
      .mclk(mclk),
      .nrst(nrst),
      .tick(tick1),
      .run(run1),
      .load(ld1),
      .initVal(init1_q),
      .ratio(second_prescaler_setup_q[PRE_RATIO_LO +: 6]),
      .modulo(second_prescaler_setup_q[PRE_MODE]),
      .count(cnt1),
      .eoc(eoc1),
      .halted(halted1)
   );

   // a trigger arms the run; a single pass or a stop disarms it
   always_ff @(posedge mclk) begin
      if (!nrst) begin
         trigRun_q <= 1'b0;
      end else if (trigEdge) begin
         trigRun_q <= 1'b1;
      end else if (!run1 || (eoc1 && !second_prescaler_setup_q[PRE_MODE])) begin
         trigRun_q <= 1'b0;
      end
   end

   // ---------------- register writes ----------------
   // load bits are strobes and never stored, so they read back as zero
   always_ff @(posedge mclk) begin
      if (!nrst) begin
         tmr_q <= TMR_RST;
         init0_q <= CNT_RST;
         init1_q <= CNT_RST;
         first_prescaler_setup_q <= PRE_RST;
         second_prescaler_setup_q <= PRE_RST;
         mask_q <= 2'h0;
      end else if (wrEn) begin
         if (selTmr) begin
            tmr_q <= pwdata[7:0] & ~TMR_LD_MASK;
         end
         if (selCnt0) begin
            init0_q <= pwdata[7:0];
         end
         if (selCnt1) begin
            init1_q <= pwdata[7:0];
         end
         if (selPre0) begin
            first_prescaler_setup_q <= pwdata[7:0];
         end
         if (selPre1) begin
            second_prescaler_setup_q <= pwdata[7:0];
         end
         if (selMask) begin
            mask_q <= pwdata[1:0];
         end
      end
   end

   // the low-EMI option is a one-time choice: the first write locks it
   always_ff @(posedge mclk) begin
      if (!nrst) begin
         emi_q <= 1'b0;
         emiLock_q <= 1'b0;
      end else if (wrEn && selOpt && !emiLock_q) begin
         emi_q <= pwdata[0];
         emiLock_q <= 1'b1;
      end
   end

   // ---------------- interrupts ----------------
   // a new end of count wins over a clear in the same cycle
   wire logic [1:0] statClr = wrStat ? pwdata[1:0] : 2'h0;
   wire logic [1:0] statD = (stat_q & ~statClr) | {eoc1, eoc0};

   always_ff @(posedge mclk) begin
      if (!nrst) begin
         stat_q <= 2'h0;
         irq0_q <= 1'b0;
         irq1_q <= 1'b0;
      end else begin
         stat_q <= statD;
         irq0_q <= eoc0;
         irq1_q <= eoc1;
      end
   end

   assign firstCounterIrq = irq0_q;
   assign secondCounterIrq = irq1_q;
   assign irq = |(stat_q & mask_q);

   // ---------------- read path ----------------
   // data is caught in the setup phase so the access phase always ends at once
   wire logic [7:0] rdMux =
      selTmr ? tmr_q :
      selCnt0 ? cnt0 :
      selCnt1 ? cnt1 :
      selStat ? {6'h00, stat_q} :
      selMask ? {6'h00, mask_q} :
      selOpt ? {6'h00, emiLock_q, emi_q} :
      8'h00;

   always_ff @(posedge mclk) begin
      if (!nrst) begin
         prdata_q <= 32'h00000000;
         pslverr_q <= 1'b0;
      end else if (setup) begin
         prdata_q <= pwrite ? 32'h00000000 : {24'h000000, rdMux};
         pslverr_q <= ~hit;
      end
   end

   assign prdata = prdata_q;
   assign pslverr = pslverr_q;
   assign pready = 1'b1;

   // ---------------- checks ----------------
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!nrst);

   a_eoc_sets_status: assert property (
      eoc0 |=> stat_q[0])
      else $error("first end of count did not set status");

   a_eoc_irq_level: assert property (
      eoc1 && mask_q[1] && !wrMask |=> irq && secondCounterIrq)
      else $error("second end of count did not raise interrupt");

   a_load_initial: assert property (
      ld0 |=> cnt0 == $past(init0_q) && !halted0)
      else $error("load did not restart from initial value");

   a_stop_holds: assert property (
      !run0 && !ld0 |=> cnt0 == $past(cnt0))
      else $error("stopped counter moved");

   a_single_halts: assert property (
      eoc0 && !first_prescaler_setup_q[PRE_MODE] && $stable(first_prescaler_setup_q) |-> cnt0 == 8'h00 && halted0)
      else $error("single pass did not halt at zero");

   a_modulo_reload: assert property (
      eoc1 && second_prescaler_setup_q[PRE_MODE] && $stable(second_prescaler_setup_q) |-> cnt1 == $past(init1_q) && !halted1)
      else $error("modulo mode did not reload");

   a_read_quiet: assert property (
      psel && penable && !pwrite && selCnt0 && !tick0 && !ld0 |=> cnt0 == $past(cnt0))
      else $error("counter read disturbed the count");

   a_emi_rate: assert property (
      tclkEn && emi_q |=> !tclkEn [*6])
      else $error("low-emi timer clock faster than 250 ns");

   a_std_halving: assert property (
      tclkEn && !emi_q |=> !tclkEn ##1 (tclkEn || emi_q))
      else $error("standard timer clock is not half of mclk");

   a_int_quarter: assert property (
      intTick && !emi_q |=> !intTick [*7])
      else $error("internal counter clock is not a quarter of timer clock");

   a_first_internal: assert property (
      pinFall && !intTick |-> !tick0)
      else $error("first counter took the external pin");
endmodule : dpdc_timer_top

// ---- dv/dpdc_timer_top_test.sv ----
`timescale 1ns/1ps
module dpdc_timer_top_test;
   import dpdc_pkg::*;
   logic mclk, nrst, psel, penable, pwrite, pready, pslverr;
   logic [ADDR_W-1:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   logic [2:0] fixedInputLines, fixedInSync;
   logic firstCounterIrq, secondCounterIrq, irq, er;
   int bad_count = 0;
   int total_checks = 0;
   int irqCnt[2] = '{0, 0};
   int t;
   logic [31:0] c1, c2, c3;

   dpdc_timer_top dpdc_timer_top_inst (.mclk(mclk), .nrst(nrst), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .fixedInputLines(fixedInputLines),
      .fixedInSync(fixedInSync), .firstCounterIrq(firstCounterIrq),
      .secondCounterIrq(secondCounterIrq), .irq(irq));

   initial begin
      mclk = 1'b0;
      forever #20 mclk = ~mclk;
   end

   // pulses last one cycle, so they are counted mid-cycle
   always @(negedge mclk) begin
      if (firstCounterIrq === 1'b1) irqCnt[0]++;
      if (secondCounterIrq === 1'b1) irqCnt[1]++;
   end

   task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
      total_checks++;
      if (got !== exp) begin
         bad_count++;
         $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
      end
   endtask : check

   task automatic finish_test();
      $display("checks %0d mismatches %0d", total_checks, bad_count);
      if (bad_count == 0 && total_checks > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask : finish_test

   task automatic apb(input logic w, input logic [7:0] idx, input logic [7:0] wd);
      int n;
      n = 0;
      @(posedge mclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= ADDR_W'({idx, 2'b00});
      pwdata <= {24'h0, wd};
      @(posedge mclk);
      penable <= 1'b1;
      @(posedge mclk);
      while (pready !== 1'b1) begin
         n++;
         if (n > 50) begin
            check("pready", 1, 0);
            finish_test();
         end
         @(posedge mclk);
      end
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb

   task automatic cycles(input int n);
      repeat (n) @(negedge mclk);
   endtask : cycles

   // waits for the next pulse of one counter and returns the cycles taken;
   // polls on the rising edge so it never races the mid-cycle pulse counter
   task automatic wait_irq(input int which, output int n);
      int s;
      s = irqCnt[which];
      n = 0;
      while (irqCnt[which] == s) begin
         @(posedge mclk);
         n++;
         if (n > 3000) begin
            check("irq wait", 1, 0);
            finish_test();
         end
      end
   endtask : wait_irq

   task automatic test_reset();
      apb(0, IDX_TMR, 0);
      check("mode reset", 0, rd);
      apb(0, IDX_MASK, 0);
      check("mask reset", 0, rd);
      apb(0, IDX_STAT, 0);
      check("status reset", 0, rd);
      apb(1, 8'h10, 8'hFF);
      check("unmapped err", 1, er);
      apb(0, 8'h10, 0);
      check("unmapped data", 0, rd);
   endtask : test_reset

   task automatic test_single_first();
      apb(1, IDX_FIRST_PRESCALER_SETUP, 8'h08);
      apb(0, IDX_FIRST_PRESCALER_SETUP, 0);
      check("prescaler read", 0, rd);
      apb(1, IDX_CNT0, 8'h03);
      apb(1, IDX_TMR, 8'h03);
      wait_irq(0, t);
      check("first eoc", 1, t <= 2 * 3 * 8 + 8);
      cycles(100);
      check("single once", 1, irqCnt[0]);
      apb(0, IDX_CNT0, 0);
      check("single halt", 0, rd);
      apb(0, IDX_STAT, 0);
      check("status set", 32'h1, rd);
      check("irq masked", 0, irq);
      apb(1, IDX_MASK, 8'h01);
      cycles(1);
      check("irq unmasked", 1, irq);
      apb(1, IDX_STAT, 8'h01);
      cycles(1);
      check("irq cleared", 0, irq);
   endtask : test_single_first

   task automatic test_modulo_second(input int unit);
      apb(1, IDX_SECOND_PRESCALER_SETUP, 8'h07);
      apb(1, IDX_CNT1, 8'h02);
      apb(1, IDX_TMR, 8'h0C);
      wait_irq(1, t);
      wait_irq(1, t);
      check("modulo period", 2 * 4 * unit, t);
      apb(1, IDX_SECOND_PRESCALER_SETUP, 8'h03);
      apb(1, IDX_CNT1, 8'h01);
      apb(1, IDX_TMR, 8'h0C);
      wait_irq(1, t);
      wait_irq(1, t);
      check("ratio 64", 64 * 4 * unit, t);
      apb(1, IDX_TMR, 8'h00);
   endtask : test_modulo_second

   task automatic test_stop_continue();
      apb(1, IDX_FIRST_PRESCALER_SETUP, 8'h04);
      apb(1, IDX_CNT0, 8'h00);
      apb(1, IDX_TMR, 8'h03);
      cycles(100);
      apb(1, IDX_TMR, 8'h00);
      apb(0, IDX_CNT0, 0);
      c1 = rd;
      check("full count", 1, c1 > 32'hE8 && c1 < 32'hF8);
      cycles(50);
      apb(0, IDX_CNT0, 0);
      check("stopped", c1, rd);
      apb(1, IDX_TMR, 8'h02);
      cycles(50);
      apb(0, IDX_CNT0, 0);
      c3 = rd;
      check("continued", 1, c3 < c1 && c3 > c1 - 12);
      apb(1, IDX_TMR, 8'h03);
      apb(0, IDX_CNT0, 0);
      check("restart", 1, rd == 0 || rd == 32'hFF);
      apb(1, IDX_TMR, 8'h00);
   endtask : test_stop_continue

   task automatic pin_edge();
      fixedInputLines[0] <= 1'b1;
      cycles(12);
      check("sync high", 1, fixedInSync[0]);
      @(posedge mclk);
      fixedInputLines[0] <= 1'b0;
      cycles(12);
      check("sync low", 0, fixedInSync[0]);
      @(posedge mclk);
   endtask : pin_edge

   task automatic test_pin();
      apb(1, IDX_SECOND_PRESCALER_SETUP, 8'h04);
      apb(1, IDX_CNT1, 8'h02);
      apb(1, IDX_TMR, 8'h0C);
      c1 = irqCnt[1];
      pin_edge();
      check("one pin edge", c1, irqCnt[1]);
      pin_edge();
      check("two pin edges", c1 + 1, irqCnt[1]);
      apb(1, IDX_SECOND_PRESCALER_SETUP, 8'h06);
      apb(1, IDX_CNT1, 8'h00);
      apb(1, IDX_TMR, 8'h4C);
      apb(0, IDX_CNT1, 0);
      c2 = rd;
      cycles(40);
      apb(0, IDX_CNT1, 0);
      check("gate closed", c2, rd);
      @(posedge mclk);
      fixedInputLines[0] <= 1'b1;
      cycles(40);
      apb(0, IDX_CNT1, 0);
      check("gate open", 1, rd != c2);
      apb(1, IDX_TMR, 8'h00);
   endtask : test_pin

   // pin is left high by the gate scenario; its fall is the trigger
   task automatic test_trigger();
      apb(1, IDX_SECOND_PRESCALER_SETUP, 8'h06);
      apb(1, IDX_CNT1, 8'h03);
      apb(1, IDX_TMR, 8'h88);
      apb(0, IDX_CNT1, 0);
      c2 = rd;
      cycles(40);
      apb(0, IDX_CNT1, 0);
      check("trigger idle", c2, rd);
      @(posedge mclk);
      fixedInputLines[0] <= 1'b0;
      wait_irq(1, t);
      check("trigger run", 1, t <= 3 * 8 + 24);
      apb(1, IDX_TMR, 8'h00);
   endtask : test_trigger

   task automatic test_low_emi();
      apb(1, IDX_OPT, 8'h01);
      apb(1, IDX_OPT, 8'h00);
      apb(0, IDX_OPT, 0);
      check("option locked", 1, rd[0]);
      test_modulo_second(7);
   endtask : test_low_emi

   initial begin
      nrst = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = '0;
      pwdata = '0;
      fixedInputLines = 3'h0;
      repeat (20) @(posedge mclk);
      nrst <= 1'b1;
      test_reset();
      test_single_first();
      test_modulo_second(2);
      test_stop_continue();
      test_pin();
      test_trigger();
      test_low_emi();
      finish_test();
   end
endmodule : dpdc_timer_top_test
